// file: hw/ucr_params.svh
// Offsets, fields, reset values and timing of the serial control block.
// Assumes byte addresses on the AXI4-Lite bus.
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH

// Register indices (byte address = 4 x index)
`define UCR_IDX_TXLO   4'h2
`define UCR_IDX_TXHI   4'h3
`define UCR_IDX_STATUS 4'h4
`define UCR_IDX_CTL_A  4'h5
`define UCR_IDX_CTL_B  4'h6
`define UCR_IDX_CTL_C  4'h7

// Reset values
`define UCR_RST_CTL_A  8'h00
`define UCR_RST_CTL_B  8'h00
`define UCR_RST_CTL_C  8'h03

// Control A fields
`define UCR_A_TXC_IE   6
`define UCR_A_DRE_IE   5
`define UCR_A_RXS_IE   4
`define UCR_A_LOOP     3
`define UCR_A_ABE_IE   2
`define UCR_A_LDRV     0

// Control B fields
`define UCR_B_RX_ON    7
`define UCR_B_TX_ON    6
`define UCR_B_SFD      4
`define UCR_B_ODRAIN   3
`define UCR_B_RXM_LSB  1
`define UCR_B_MPM      0

// Control C fields, normal and host SPI layout
`define UCR_C_CM_LSB   6
`define UCR_C_PM_LSB   4
`define UCR_C_STOP2    3
`define UCR_C_CS_LSB   0
`define UCR_C_LSBF     2
`define UCR_C_LATE     1

// Status fields
`define UCR_S_TXC      6
`define UCR_S_DRE      5
`define UCR_S_RXS      4
`define UCR_S_ISF      3

// Clock cycles per transmitted bit
`define UCR_BIT_CYCLES 16'd16

`endif

// file: hw/ucr_pkg.sv
// Types of the serial control block.
// Assumes numbers come from ucr_params.svh.
package ucr_pkg;

   typedef enum logic [1:0] {
      ucr_cm_async = 2'h0,
      ucr_cm_sync  = 2'h1,
      ucr_cm_ir    = 2'h2,
      ucr_cm_spi   = 2'h3
   } ucr_communication_mode_t;

   typedef enum logic [1:0] {
      ucr_rx_normal       = 2'h0,
      ucr_rx_double_speed = 2'h1,
      ucr_rx_generic_auto = 2'h2,
      ucr_rx_lin_auto     = 2'h3
   } ucr_receiver_speed_mode_t;

   typedef enum logic [1:0] {
      ucr_par_none     = 2'h0,
      ucr_par_reserved = 2'h1,
      ucr_par_even     = 2'h2,
      ucr_par_odd      = 2'h3
   } ucr_parity_t;

   typedef enum logic [2:0] {
      ucr_cs_5     = 3'h0,
      ucr_cs_6     = 3'h1,
      ucr_cs_7     = 3'h2,
      ucr_cs_8     = 3'h3,
      ucr_cs_res4  = 3'h4,
      ucr_cs_res5  = 3'h5,
      ucr_cs_9low  = 3'h6,
      ucr_cs_9high = 3'h7
   } ucr_character_size_t;

   typedef enum logic [1:0] {
      ucr_tx_idle  = 2'b01,
      ucr_tx_shift = 2'b10
   } ucr_txst_t;

   typedef struct packed {
      logic        receiver_on;
      logic        transmitter_on;
      logic        start_frame_detect_enable;
      logic        open_drain_enable;
      ucr_receiver_speed_mode_t receiver_speed_mode;
      logic        multiprocessor_mode;
      logic        line_driver_mode_enable;
      logic        loopback_enable;
      ucr_communication_mode_t  communication_mode;
      ucr_parity_t parity_mode;
      logic        stop_bit_mode;
      ucr_character_size_t character_size;
      logic        spi_lsb_first;
      logic        spi_late_sample;
   } ucr_cfg_t;

   typedef struct packed {
      logic tx_complete;
      logic data_empty;
      logic rx_start;
      logic autobaud_err;
   } ucr_irq_t;

   typedef struct packed {
      logic [3:0] nbits;
      logic       parity_on;
      logic       parity_odd;
      logic       two_stop;
   } ucr_frame_t;

endpackage

// file: hw/ucr_tx_shift.sv
// Transmit shift register: serialises one frame, LSB first.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "ucr_params.svh"

module ucr_tx_shift
   import ucr_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             start,
   input  wire logic [8:0]       data,
   input  wire ucr_pkg::ucr_frame_t fmt,
   output logic                  busy,
   output logic                  line,
   output logic                  done
);
   ucr_txst_t   st_r, st_nxt;
   logic [12:0] frame_r, frame_nxt, frame_new;
   logic [3:0]  left_r, left_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        line_r, line_nxt;
   logic        done_r, done_nxt;
   logic        par;
   logic [3:0]  total;

   // -------------------------------------------------------------
   // Frame build and bit timing
   // -------------------------------------------------------------
   always_comb begin
      frame_new = 13'h1fff;
      frame_new[0] = 1'b0;
      par = fmt.parity_odd;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(fmt.nbits)) begin
            frame_new[i+1] = data[i];
            par = par ^ data[i];
         end
      end
      if (fmt.parity_on) begin
         frame_new[fmt.nbits+4'd1] = par;
      end
      total = 4'd1 + fmt.nbits + {3'h0, fmt.parity_on} + {3'h0, fmt.two_stop};
      st_nxt = st_r;
      frame_nxt = frame_r;
      left_nxt = left_r;
      cnt_nxt = cnt_r;
      line_nxt = line_r;
      done_nxt = 1'b0;
      unique case (st_r)
         ucr_tx_idle: begin
            line_nxt = 1'b1;
            if (start) begin
               frame_nxt = frame_new;
               line_nxt = frame_new[0];
               left_nxt = total;
               cnt_nxt = `UCR_BIT_CYCLES - 16'd1;
               st_nxt = ucr_tx_shift;
            end
         end
         ucr_tx_shift: begin
            if (cnt_r != 16'd0) begin
               cnt_nxt = cnt_r - 16'd1;
            end else if (left_r == 4'd0) begin
               line_nxt = 1'b1;
               done_nxt = 1'b1;
               st_nxt = ucr_tx_idle;
            end else begin
               frame_nxt = {1'b1, frame_r[12:1]};
               line_nxt = frame_r[1];
               left_nxt = left_r - 4'd1;
               cnt_nxt = `UCR_BIT_CYCLES - 16'd1;
            end
         end
         default: st_nxt = ucr_tx_idle;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ucr_tx_idle;
         frame_r <= 13'h1fff;
         left_r <= 4'h0;
         cnt_r <= 16'h0;
         line_r <= 1'b1;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         frame_r <= frame_nxt;
         left_r <= left_nxt;
         cnt_r <= cnt_nxt;
         line_r <= line_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = (st_r == ucr_tx_shift);
   assign line = line_r;
   assign done = done_r;
endmodule
`default_nettype wire

// file: hw/ucr_regs.sv
// Serial transceiver control registers, transmit buffer and line side.
// Assumes an AXI4-Lite master on aclk; rxd_pin is asynchronous.
//
// Notes on behaviour
// RL1: Transmit-complete request = flag AND enable.
// RL2: Data-empty request = flag AND enable.
// RL3: Receive-start request = flag AND enable.
// RL4: Loop-back feeds transmit line to receiver, pin cut off.
// RL5: Auto-baud error request = sync-error flag AND enable.
// RL6: Bit enables line-driver mode.
// RL7: Bit turns receiver on.
// RL8: Bit turns transmitter on.
// RL9: Bit enables start-of-frame detection.
// RL10: Bit makes transmit pin open-drain, else push-pull.
// RL11: Receiver mode: normal, double speed, generic or LIN auto-baud.
// RL12: Software keeps receiver mode 0 in async and infrared.
// RL13: Bit enables multiprocessor mode.
// RL14: Communication mode: async, sync, infrared or host SPI.
// RL15: Host SPI code selects alternate control C layout.
// RL16: Parity: 0 off, 2 even, 3 odd, 1 reserved.
// RL17: Stop-bit bit: one or two transmit stop bits.
// RL18: Character size 5 to 8 bits, or 9 bits low or high first.
// RL19: Nine-bit low-first commits on high byte, else low byte.
// RL20: TX-complete sets when shifter and buffer empty; write one clears.
// RL21: Requests are flag AND enable, every clock.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ucr_params.svh"

module ucr_regs
   import ucr_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rxd_pin,
   input  wire logic        sync_field_error_evt,
   output logic             txd_o,
   output logic             txd_oe_n,
   output logic             line_drv_en,
   output logic             rx_line,
   output ucr_pkg::ucr_cfg_t cfg,
   output ucr_pkg::ucr_irq_t irq
);
   import ucr_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   function automatic logic idx_mapped(input logic [3:0] idx);
      idx_mapped = (idx >= `UCR_IDX_TXLO) && (idx <= `UCR_IDX_CTL_C);
   endfunction

   function automatic logic [3:0] size_bits(input ucr_character_size_t cs);
      unique case (cs)
         ucr_cs_5:     size_bits = 4'd5;
         ucr_cs_6:     size_bits = 4'd6;
         ucr_cs_7:     size_bits = 4'd7;
         ucr_cs_9low,
         ucr_cs_9high: size_bits = 4'd9;
         default:      size_bits = 4'd8;
      endcase
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic        aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
   logic [3:0]  wr_idx_r, wr_idx_nxt;
   logic [7:0]  wr_dat_r, wr_dat_nxt;
   logic        wr_stb_r, wr_stb_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        ar_rdy_r, ar_rdy_nxt, rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;

   logic [7:0]  ctl_a_r, ctl_a_nxt, ctl_b_r, ctl_b_nxt, ctl_c_r, ctl_c_nxt;
   logic        txc_r, txc_nxt, rxs_r, rxs_nxt, isf_r, isf_nxt;
   logic [7:0]  tx_lo_r, tx_lo_nxt;
   logic        tx_hi_r, tx_hi_nxt;
   logic [8:0]  buf_r, buf_nxt;
   logic        full_r, full_nxt;

   logic        rxd_s1_r, rxd_s2_r;
   logic        rxl_r, rxl_nxt, rxl_prev_r;
   logic        txd_r, txd_nxt, oe_n_r, oe_n_nxt, drv_r, drv_nxt;
   ucr_irq_t    irq_r, irq_nxt;

   logic        do_write, wr_hit, sel_lo, sel_hi, commit, start;
   logic        sh_busy, sh_line, sh_done, spi, rx_fall;
   logic [7:0]  status_rd, ctl_c_rd;
   ucr_cfg_t    cfg_w;
   ucr_frame_t  fmt;

   // -------------------------------------------------------------
   // Field decode
   // -------------------------------------------------------------
   always_comb begin
      cfg_w.receiver_on = ctl_b_r[`UCR_B_RX_ON]; // RL7
      cfg_w.transmitter_on = ctl_b_r[`UCR_B_TX_ON]; // RL8
      cfg_w.start_frame_detect_enable = ctl_b_r[`UCR_B_SFD]; // RL9
      cfg_w.open_drain_enable = ctl_b_r[`UCR_B_ODRAIN];
      cfg_w.receiver_speed_mode =
         ucr_receiver_speed_mode_t'(ctl_b_r[`UCR_B_RXM_LSB +: 2]); // RL11
      cfg_w.multiprocessor_mode = ctl_b_r[`UCR_B_MPM]; // RL13
      cfg_w.line_driver_mode_enable = ctl_a_r[`UCR_A_LDRV]; // RL6
      cfg_w.loopback_enable = ctl_a_r[`UCR_A_LOOP];
      cfg_w.communication_mode = ucr_communication_mode_t'(ctl_c_r[`UCR_C_CM_LSB +: 2]); // RL14
      spi = (cfg_w.communication_mode == ucr_cm_spi);
      // Host SPI layout hides the normal frame fields
      cfg_w.parity_mode = spi ? ucr_par_none
                              : ucr_parity_t'(ctl_c_r[`UCR_C_PM_LSB +: 2]); // RL15
      cfg_w.stop_bit_mode = spi ? 1'b0 : ctl_c_r[`UCR_C_STOP2]; // RL15
      cfg_w.character_size = spi ? ucr_cs_8
                                 : ucr_character_size_t'(ctl_c_r[`UCR_C_CS_LSB +: 3]); // RL18
      cfg_w.spi_lsb_first = spi & ctl_c_r[`UCR_C_LSBF]; // RL15
      cfg_w.spi_late_sample = spi & ctl_c_r[`UCR_C_LATE]; // RL15
      fmt.nbits = size_bits(cfg_w.character_size); // RL18
      fmt.parity_on = cfg_w.parity_mode[1]; // RL16
      fmt.parity_odd = (cfg_w.parity_mode == ucr_par_odd); // RL16
      fmt.two_stop = cfg_w.stop_bit_mode; // RL17
      ctl_c_rd = spi ? {ctl_c_r[7:6], 3'h0, ctl_c_r[2:1], 1'b0} : ctl_c_r;
      status_rd = 8'h00;
      status_rd[`UCR_S_TXC] = txc_r;
      status_rd[`UCR_S_DRE] = ~full_r;
      status_rd[`UCR_S_RXS] = rxs_r;
      status_rd[`UCR_S_ISF] = isf_r;
   end

   // -------------------------------------------------------------
   // AXI4-Lite write and read channels
   // -------------------------------------------------------------
   always_comb begin
      aw_rdy_nxt = aw_rdy_r;
      w_rdy_nxt = w_rdy_r;
      wr_idx_nxt = wr_idx_r;
      wr_dat_nxt = wr_dat_r;
      wr_stb_nxt = wr_stb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      do_write = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;
      wr_hit = do_write & idx_mapped(wr_idx_r) & wr_stb_r;
      if (s_axi_awvalid && aw_rdy_r) begin
         aw_rdy_nxt = 1'b0;
         wr_idx_nxt = s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && w_rdy_r) begin
         w_rdy_nxt = 1'b0;
         wr_dat_nxt = s_axi_wdata[7:0];
         wr_stb_nxt = s_axi_wstrb[0];
      end
      if (do_write) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = idx_mapped(wr_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
         aw_rdy_nxt = 1'b1;
         w_rdy_nxt = 1'b1;
      end
      ar_rdy_nxt = ar_rdy_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && ar_rdy_r) begin
         ar_rdy_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = idx_mapped(s_axi_araddr[5:2]) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr[5:2])
            `UCR_IDX_TXLO:   rdata_nxt = {24'h0, tx_lo_r};
            `UCR_IDX_TXHI:   rdata_nxt = {31'h0, tx_hi_r};
            `UCR_IDX_STATUS: rdata_nxt = {24'h0, status_rd};
            `UCR_IDX_CTL_A:  rdata_nxt = {24'h0, ctl_a_r};
            `UCR_IDX_CTL_B:  rdata_nxt = {24'h0, ctl_b_r};
            `UCR_IDX_CTL_C:  rdata_nxt = {24'h0, ctl_c_rd};
            default:         rdata_nxt = 32'h0;
         endcase
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
         ar_rdy_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         wr_idx_r <= 4'h0;
         wr_dat_r <= 8'h00;
         wr_stb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         ar_rdy_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= 2'h0;
      end else begin
         aw_rdy_r <= aw_rdy_nxt;
         w_rdy_r <= w_rdy_nxt;
         wr_idx_r <= wr_idx_nxt;
         wr_dat_r <= wr_dat_nxt;
         wr_stb_r <= wr_stb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ar_rdy_r <= ar_rdy_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // -------------------------------------------------------------
   // Control registers, status flags and transmit buffer
   // -------------------------------------------------------------
   always_comb begin
      ctl_a_nxt = ctl_a_r;
      ctl_b_nxt = ctl_b_r;
      ctl_c_nxt = ctl_c_r;
      tx_lo_nxt = tx_lo_r;
      tx_hi_nxt = tx_hi_r;
      buf_nxt = buf_r;
      full_nxt = full_r;
      sel_lo = wr_hit && (wr_idx_r == `UCR_IDX_TXLO) && !full_r;
      sel_hi = wr_hit && (wr_idx_r == `UCR_IDX_TXHI) && !full_r;
      if (wr_hit && wr_idx_r == `UCR_IDX_CTL_A) begin
         ctl_a_nxt = wr_dat_r & 8'h7d;
      end
      if (wr_hit && wr_idx_r == `UCR_IDX_CTL_B) begin
         ctl_b_nxt = wr_dat_r & 8'hdf;
      end
      if (wr_hit && wr_idx_r == `UCR_IDX_CTL_C) begin
         ctl_c_nxt = wr_dat_r;
      end
      if (sel_lo) begin
         tx_lo_nxt = wr_dat_r;
      end
      if (sel_hi) begin
         tx_hi_nxt = wr_dat_r[0];
      end
      commit = (cfg_w.character_size == ucr_cs_9low) ? sel_hi : sel_lo; // RL19
      start = full_r && !sh_busy && cfg_w.transmitter_on; // RL8
      if (start) begin
         full_nxt = 1'b0;
      end
      if (commit) begin
         buf_nxt = {tx_hi_nxt, tx_lo_nxt}; // RL19
         full_nxt = 1'b1;
      end
      // Hardware set wins over a same-cycle write-one clear
      txc_nxt = txc_r;
      rxs_nxt = rxs_r;
      isf_nxt = isf_r;
      if (wr_hit && wr_idx_r == `UCR_IDX_STATUS) begin
         if (wr_dat_r[`UCR_S_TXC]) txc_nxt = 1'b0; // RL20
         if (wr_dat_r[`UCR_S_RXS]) rxs_nxt = 1'b0;
         if (wr_dat_r[`UCR_S_ISF]) isf_nxt = 1'b0;
      end
      if (sh_done && !full_r) begin
         txc_nxt = 1'b1; // RL20
      end
      if (rx_fall && cfg_w.start_frame_detect_enable && cfg_w.receiver_on && !spi) begin
         rxs_nxt = 1'b1; // RL9
      end
      if (sync_field_error_evt && cfg_w.receiver_speed_mode[1]) begin
         isf_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_a_r <= `UCR_RST_CTL_A;
         ctl_b_r <= `UCR_RST_CTL_B;
         ctl_c_r <= `UCR_RST_CTL_C;
         tx_lo_r <= 8'h00;
         tx_hi_r <= 1'b0;
         buf_r <= 9'h000;
         full_r <= 1'b0;
         txc_r <= 1'b0;
         rxs_r <= 1'b0;
         isf_r <= 1'b0;
      end else begin
         ctl_a_r <= ctl_a_nxt;
         ctl_b_r <= ctl_b_nxt;
         ctl_c_r <= ctl_c_nxt;
         tx_lo_r <= tx_lo_nxt;
         tx_hi_r <= tx_hi_nxt;
         buf_r <= buf_nxt;
         full_r <= full_nxt;
         txc_r <= txc_nxt;
         rxs_r <= rxs_nxt;
         isf_r <= isf_nxt;
      end
   end

   ucr_tx_shift u_shift (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start),
      .data    (buf_r),
      .fmt     (fmt),
      .busy    (sh_busy),
      .line    (sh_line),
      .done    (sh_done)
   );

   // -------------------------------------------------------------
   // Line side and interrupt requests
   // -------------------------------------------------------------
   always_comb begin
      rxl_nxt = cfg_w.loopback_enable ? sh_line : rxd_s2_r; // RL4
      rx_fall = rxl_prev_r & ~rxl_r;
      if (cfg_w.open_drain_enable) begin
         txd_nxt = 1'b0; // RL10
         oe_n_nxt = sh_line | ~cfg_w.transmitter_on; // RL10
      end else begin
         txd_nxt = sh_line;
         oe_n_nxt = ~cfg_w.transmitter_on;
      end
      drv_nxt = cfg_w.line_driver_mode_enable & sh_busy; // RL6
      irq_nxt.tx_complete = txc_r & ctl_a_r[`UCR_A_TXC_IE]; // RL1 RL21
      irq_nxt.data_empty = ~full_r & ctl_a_r[`UCR_A_DRE_IE]; // RL2 RL21
      irq_nxt.rx_start = rxs_r & ctl_a_r[`UCR_A_RXS_IE]; // RL3 RL21
      irq_nxt.autobaud_err = isf_r & ctl_a_r[`UCR_A_ABE_IE]; // RL5 RL21
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         rxl_r <= 1'b1;
         rxl_prev_r <= 1'b1;
         txd_r <= 1'b1;
         oe_n_r <= 1'b1;
         drv_r <= 1'b0;
         irq_r <= '0;
      end else begin
         rxd_s1_r <= rxd_pin;
         rxd_s2_r <= rxd_s1_r;
         rxl_r <= rxl_nxt;
         rxl_prev_r <= rxl_r;
         txd_r <= txd_nxt;
         oe_n_r <= oe_n_nxt;
         drv_r <= drv_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign cfg = cfg_w;
   assign irq = irq_r;
   assign txd_o = txd_r;
   assign txd_oe_n = oe_n_r;
   assign line_drv_en = drv_r;
   assign rx_line = rxl_r;
   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = w_rdy_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ar_rdy_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// file: testbench/ucr_regs_asserts.sv
// Port checker for the serial control block.
// Assumes it is bound into ucr_regs, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ucr_regs_asserts
   import ucr_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              txd_o,
   input wire logic              txd_oe_n,
   input wire logic              line_drv_en,
   input wire logic              rx_line,
   input wire logic              rxd_pin,
   input wire ucr_pkg::ucr_cfg_t cfg
);
   // ----
   // Properties
   // ----
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence bit_low;
      !txd_o [*8];
   endsequence
   sequence loop_on;
      (cfg.loopback_enable && $stable(txd_o)) [*4];
   endsequence
   sequence loop_off;
      (!cfg.loopback_enable && $stable(rxd_pin)) [*4];
   endsequence
   a_loop_route: assert property (loop_on |-> rx_line == txd_o)
      else $error("loop route");
   a_pin_route: assert property (loop_off |-> rx_line == rxd_pin)
      else $error("pin route");
   a_ldrv_gate: assert property (line_drv_en |-> $past(cfg.line_driver_mode_enable))
      else $error("driver gate");
   a_od_low: assert property (cfg.open_drain_enable [*2] |-> !txd_o)
      else $error("open drain level");
   a_pp_drive: assert property ((cfg.transmitter_on && !cfg.open_drain_enable) [*2]
      |-> !txd_oe_n)
      else $error("push pull drive");
   a_tx_off: assert property ((!cfg.transmitter_on) [*2] |-> txd_oe_n)
      else $error("pin not released");
   a_bit_hold: assert property ($fell(txd_o) |-> bit_low)
      else $error("bit too short");
   a_spi_fmt: assert property (cfg.communication_mode == ucr_cm_spi |->
      cfg.parity_mode == ucr_par_none && !cfg.stop_bit_mode
      && cfg.character_size == ucr_cs_8)
      else $error("spi layout");
   a_norm_fmt: assert property (cfg.communication_mode != ucr_cm_spi |->
      !cfg.spi_lsb_first && !cfg.spi_late_sample)
      else $error("normal layout");
endmodule
bind ucr_regs ucr_regs_asserts u_chk (.aclk, .aresetn, .txd_o, .txd_oe_n,
   .line_drv_en, .rx_line, .rxd_pin, .cfg);
`default_nettype wire

// file: testbench/ucr_remote_node.sv
// Remote serial node: decodes frames on the transmit pin.
// Assumes 16 clocks per bit; pin has a pull-up when released.
`timescale 1ns/1ps
`default_nettype none
module ucr_remote_node (
   input  wire logic       aclk,
   input  wire logic       txd_o,
   input  wire logic       txd_oe_n,
   input  wire logic       pull_low,
   input  wire logic [3:0] nbits,
   output logic            rxd_pin,
   output var logic [8:0]  word,
   output var int          frames
);
   // ----
   // Line decode
   // ----
   wire logic line = txd_oe_n ? 1'b1 : txd_o;
   assign rxd_pin = !pull_low;
   initial begin
      frames = 0;
      forever begin
         @(negedge line);
         repeat (8) @(posedge aclk);
         word = '0;
         for (int i = 0; i < nbits; i++) begin
            repeat (16) @(posedge aclk);
            word[i] = line;
         end
         repeat (16) @(posedge aclk);
         frames++;
      end
   end
endmodule
`default_nettype wire

// file: testbench/ucr_regs_tb.sv
// Testbench: register and frame tests over AXI4-Lite.
// Assumes ucr_remote_node on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module ucr_regs_tb;
   import ucr_pkg::*;
   // ----
   // Signals and tasks
   // ----
   logic       aclk, aresetn, sync_field_error_evt, pull_low;
   logic       s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic       txd_o, txd_oe_n, line_drv_en, rx_line, rxd_pin;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, nbits;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [8:0] word;
   logic [7:0] c;
   int         frames, errors, check_count, f0;
   ucr_cfg_t   cfg;
   ucr_irq_t   irq;
   ucr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_pin,
      .sync_field_error_evt, .txd_o, .txd_oe_n, .line_drv_en, .rx_line, .cfg, .irq);
   ucr_remote_node peer (.aclk, .txd_o, .txd_oe_n, .pull_low, .nbits, .rxd_pin,
      .word, .frames);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic give_verdict;
      if (errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [39:0] ex, input logic [39:0] sn);
      check_count++;
      if (sn !== ex) begin
         errors++;
         $display("mismatch %s exp %h got %h", nm, ex, sn);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 400) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      tmo(n);
      s_axi_bready <= 1'b0;
      cmp("bresp", r, s_axi_bresp);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      tmo(n);
      s_axi_rready <= 1'b0;
      cmp("rdata", {r, 24'h0, d}, {s_axi_rresp, s_axi_rdata});
   endtask
   task automatic wirq(input int k, input logic v);
      int n;
      for (n = 0; n < 400 && irq[k] !== v; n++) @(posedge aclk);
      tmo(n);
      check_count++;
   endtask
   task automatic wframe(input logic [8:0] d);
      int n;
      for (n = 0; n < 400 && frames == f0; n++) @(posedge aclk);
      tmo(n);
      f0 = frames;
      cmp("frame", d, word);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, sync_field_error_evt, pull_low, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, errors, check_count, f0} = '0;
      s_axi_wstrb = 4'h1;
      nbits = 4'd8;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(6'h14, 8'h00);
      rd(6'h18, 8'h00);
      rd(6'h1c, 8'h03);
      rd(6'h10, 8'h20);
      rd(6'h00, 8'h00, 2'b10);
      wr(6'h3c, 8'hff, 2'b10);
      wr(6'h1c, 8'h43);
      for (int i = 0; i < 4; i++) begin
         wr(6'h18, 8'hf9 | 8'(i << 1));
         rd(6'h18, 8'hd9 | 8'(i << 1));
         cmp("cfg_b", {4'hf, 2'(i), 1'b1}, cfg[18:12]);
      end
      wr(6'h18, 8'h00);
      for (int j = 0; j < 8; j++) begin
         c = {j[1:0], j[1:0], j[0], j[2:0]};
         wr(6'h1c, c);
         rd(6'h1c, (c[7:6] == 2'h3) ? c & 8'hc6 : c);
         cmp("cfg_c", (c[7:6] == 2'h3) ? {8'hc3, c[2:1]} : {c, 2'b00}, cfg[9:0]);
      end
      wr(6'h1c, 8'h03);
      wr(6'h18, 8'h40);
      wr(6'h14, 8'h61);
      wirq(2, 1'b1);
      wr(6'h08, 8'ha5);
      wframe(9'h0a5);
      wirq(3, 1'b1);
      wr(6'h10, 8'h40);
      wirq(3, 1'b0);
      wr(6'h14, 8'h00);
      wirq(2, 1'b0);
      wr(6'h1c, 8'h2e);
      nbits <= 4'd9;
      wr(6'h08, 8'h33);
      rd(6'h10, 8'h20);
      wr(6'h0c, 8'h01);
      wframe(9'h133);
      pull_low <= 1'b1;
      wr(6'h14, 8'h08);
      repeat (4) @(posedge aclk);
      cmp("rx_line", 1, rx_line);
      wr(6'h14, 8'h00);
      repeat (4) @(posedge aclk);
      cmp("rx_line", 0, rx_line);
      pull_low <= 1'b0;
      wr(6'h18, 8'hd0);
      wr(6'h14, 8'h10);
      pull_low <= 1'b1;
      wirq(1, 1'b1);
      wr(6'h10, 8'h10);
      wirq(1, 1'b0);
      wr(6'h1c, 8'h43);
      wr(6'h18, 8'h84);
      wr(6'h14, 8'h04);
      sync_field_error_evt <= 1'b1;
      @(posedge aclk);
      sync_field_error_evt <= 1'b0;
      wirq(0, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
